//--- core/rpcat_core.sv
// packet configuration decoder and auto-respond turnaround sequencer
// How it works
// - auto-respond command: opcode, delay high, low
// - gap equals delay minus 33 microseconds
// - armed: every received packet not dropped as oversize triggers a transmit
// - zero delay disarms; armed transmit returns to receive, unarmed to standby
// - calibrate after reset, then standby, busy low
// - carrier word in synthesizer steps, used for transmit
// - receive carrier lowered by intermediate frequency
// - payload bases offset from buffer start
// - first modulation code selects rate and bandwidth
// - second modulation code selects coding rate
// - third modulation code selects pulse shaping
// - preamble length in four-bit steps, zero reserved
// - sync size code adds 32-bit word
// - three correlators, any enabled word accepted
// - fourth format code selects fixed or variable
// - transmit exact length; drop oversize variable packets
// - sixth format code selects crc byte count
// - crc seed and generator from byte registers
`timescale 1ns/1ps
module rpcat_core #(
   parameter int CAL_CYCLES = 1024
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic cmd_valid,
   input wire logic cmd_start,
   input wire logic [7:0] cmd_data,
   input wire logic rx_start,
   input wire logic tx_request,
   input wire logic rx_end,
   input wire logic [7:0] rx_len,
   input wire logic tx_end,
   output logic busy,
   output rpcat_pkg::rpcat_mode_type mode,
   output logic auto_armed,
   output logic tx_start,
   output logic rx_discard,
   output logic param_error,
   output rpcat_pkg::rpcat_cfg_type cfg
);
   import rpcat_pkg::*;

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   function automatic logic [3:0] args_of(input logic [7:0] op);
      logic [3:0] n;
      n = 4'h0;
      unique case (op)
         OP_AUTO_RESPOND: n = ARGS_AUTO;
         OP_ENTER_STANDBY: n = ARGS_ONE;
         OP_SELECT_KIND: n = ARGS_ONE;
         OP_SET_CARRIER: n = ARGS_CARRIER;
         OP_SET_BASES: n = ARGS_BASES;
         OP_SET_MODULATION: n = ARGS_MOD;
         OP_SET_FORMAT: n = ARGS_FORMAT;
         default: n = ARGS_MAX;
      endcase
      return n;
   endfunction

   // step codes 0x10..0x70 with a clear low nibble, plus 0x00 when zero_ok
   function automatic logic step_code_ok(input logic [7:0] c, input logic zero_ok);
      return (c[3:0] == 4'h0) && (c <= CODE_STEP_MAX) && (zero_ok || (c != 8'h00));
   endfunction

   // one helper per legal-code set size keeps the coding, shaping, sync and size checks alike
   function automatic logic one_of3(input logic [7:0] c, input logic [7:0] a,
      input logic [7:0] b, input logic [7:0] e);
      return (c == a) || (c == b) || (c == e);
   endfunction

   function automatic logic one_of2(input logic [7:0] c, input logic [7:0] a,
      input logic [7:0] b);
      return (c == a) || (c == b);
   endfunction

   // shaping and crc size share the same two-bit field of their codes
   function automatic logic [1:0] pair_of(input logic [7:0] c);
      return c[5:4];
   endfunction

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   rpcat_mode_type mode_q;
   logic [$clog2(CAL_CYCLES+1)-1:0] cal_cnt_q;
   logic [7:0] op_q;
   logic [3:0] idx_q;
   logic [7:0] args_q [0:ARG_DEPTH-1];
   logic [7:0] cur [0:ARG_DEPTH-1];
   logic [15:0] auto_gap_q;
   logic [15:0] us_cnt_q;
   logic [7:0] pre_cnt_q;
   logic tx_start_q;
   logic rx_discard_q;
   logic param_error_q;
   rpcat_cfg_type cfg_q;
   logic take;
   logic done;
   logic reg_we;
   logic [15:0] reg_addr;
   logic mod_ok;
   logic fmt_ok;
   rpcat_rate_type rate_d;
   logic gap_over;
   logic oversize;

   assign busy = (mode_q != RPCAT_STANDBY);
   assign mode = mode_q;
   assign auto_armed = (auto_gap_q != 16'h0000);
   assign tx_start = tx_start_q;
   assign rx_discard = rx_discard_q;
   assign param_error = param_error_q;
   assign cfg = cfg_q;

   // -----------------------------------------------------------------
   // command byte collection
   // -----------------------------------------------------------------
   // commands are heard only in standby; bytes in other modes are dropped
   assign take = cmd_valid && (mode_q == RPCAT_STANDBY);
   assign done = take && !cmd_start && (op_q != OP_REGISTER_WRITE)
                 && (idx_q == args_of(op_q) - 4'h1);
   assign reg_we = take && !cmd_start && (op_q == OP_REGISTER_WRITE)
                   && (idx_q >= ARGS_REG_ADDR);
   assign reg_addr = {args_q[0], args_q[1]} + 16'({12'h000, idx_q} - 16'(ARGS_REG_ADDR));

   always_comb begin
      for (int i = 0; i < ARG_DEPTH; i++) begin
         cur[i] = args_q[i];
      end
      if (idx_q < 4'(ARG_DEPTH)) begin
         cur[idx_q[2:0]] = cmd_data;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         op_q <= 8'h00;
         idx_q <= 4'h0;
      end else if (take) begin
         if (cmd_start) begin
            op_q <= cmd_data;
            idx_q <= 4'h0;
         end else if (idx_q != ARGS_MAX) begin
            idx_q <= idx_q + 4'h1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < ARG_DEPTH; i++) begin
            args_q[i] <= 8'h00;
         end
      end else if (take && !cmd_start && (idx_q < 4'(ARG_DEPTH))) begin
         args_q[idx_q[2:0]] <= cmd_data;
      end
   end

   // -----------------------------------------------------------------
   // parameter checks
   // -----------------------------------------------------------------
   always_comb begin
      rate_d = RATE_1300;
      mod_ok = 1'b1;
      unique case (cur[0])
         BR_1300: rate_d = RATE_1300;
         BR_1040: rate_d = RATE_1040;
         BR_650: rate_d = RATE_650;
         BR_520: rate_d = RATE_520;
         BR_325: rate_d = RATE_325;
         BR_260: rate_d = RATE_260;
         default: mod_ok = 1'b0;
      endcase
      if (!one_of3(cur[1], CR_HALF, CR_THREE_QUARTER, CR_UNCODED)) begin
         mod_ok = 1'b0;
      end
      if (!one_of3(cur[2], BT_OFF, BT_ONE, BT_HALF)) begin
         mod_ok = 1'b0;
      end
   end

   // a rejected set leaves the previous configuration in place
   assign fmt_ok = step_code_ok(cur[0], 1'b0)
                   && one_of2(cur[1], SYNC_NONE, SYNC_WORD32)
                   && step_code_ok(cur[2], 1'b1)
                   && one_of2(cur[3], FIXED_SIZE_FRAMES, VARIABLE_SIZE_FRAMES)
                   && step_code_ok(cur[5], 1'b1) && (cur[5] <= CRC_THREE)
                   && (cur[6] == WHITENING_OFF);

   // -----------------------------------------------------------------
   // configuration registers
   // -----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cfg_q <= '0;
         param_error_q <= 1'b0;
      end else begin
         cfg_q.rx_carrier_word <= cfg_q.tx_carrier_word - IF_STEPS;
         if (done) begin
            unique case (op_q)
               OP_SELECT_KIND: cfg_q.packet_kind <= cur[0];
               OP_SET_CARRIER: cfg_q.tx_carrier_word <= {cur[0], cur[1], cur[2]};
               OP_SET_BASES: begin
                  cfg_q.transmit_base_offset <= cur[0];
                  cfg_q.receive_base_offset <= cur[1];
               end
               OP_SET_MODULATION: begin
                  param_error_q <= !mod_ok;
                  if (mod_ok) begin
                     cfg_q.rate <= rate_d;
                     cfg_q.coding_rate <= cur[1][2:1];
                     cfg_q.shaping <= pair_of(cur[2]);
                  end
               end
               OP_SET_FORMAT: begin
                  param_error_q <= !fmt_ok;
                  if (fmt_ok) begin
                     cfg_q.gain_training_length <= 6'({2'b00, cur[0][7:4]} + 6'h01)
                                                   * PREAMBLE_STEP_BITS;
                     cfg_q.sync_word_on <= (cur[1] == SYNC_WORD32);
                     cfg_q.sync_accept_mask <= cur[2][6:4];
                     cfg_q.variable_size <= (cur[3] == VARIABLE_SIZE_FRAMES);
                     cfg_q.payload_length <= cur[4];
                     cfg_q.crc_bytes <= pair_of(cur[5]);
                  end
               end
               default: begin
               end
            endcase
         end
         if (reg_we) begin
            unique case (reg_addr)
               ADDR_CRC_POLY_HIGH: cfg_q.crc_generator[15:8] <= cmd_data;
               ADDR_CRC_POLY_LOW: cfg_q.crc_generator[7:0] <= cmd_data;
               ADDR_CRC_SEED_HIGH: cfg_q.crc_seed[15:8] <= cmd_data;
               ADDR_CRC_SEED_LOW: cfg_q.crc_seed[7:0] <= cmd_data;
               default: begin
               end
            endcase
         end
      end
   end

   // -----------------------------------------------------------------
   // auto-respond delay
   // -----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         auto_gap_q <= 16'h0000;
      end else if (done && (op_q == OP_AUTO_RESPOND)) begin
         auto_gap_q <= {cur[0], cur[1]};
      end
   end

   // -----------------------------------------------------------------
   // mode sequencer
   // -----------------------------------------------------------------
   assign oversize = cfg_q.variable_size && (rx_len > cfg_q.payload_length);
   assign gap_over = (us_cnt_q == 16'h0000) && (pre_cnt_q == 8'h00);

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         mode_q <= RPCAT_CAL;
         cal_cnt_q <= '0;
      end else begin
         unique case (mode_q)
            RPCAT_CAL: begin
               // calibration holds busy high for a fixed time after reset
               cal_cnt_q <= cal_cnt_q + 1'b1;
               if (cal_cnt_q == ($clog2(CAL_CYCLES+1))'(CAL_CYCLES - 1)) begin
                  mode_q <= RPCAT_STANDBY;
               end
            end
            RPCAT_STANDBY: begin
               if (rx_start) begin
                  mode_q <= RPCAT_RECEIVE;
               end else if (tx_request) begin
                  mode_q <= RPCAT_TRANSMIT;
               end
            end
            RPCAT_RECEIVE: begin
               if (rx_end && !oversize) begin
                  mode_q <= auto_armed ? RPCAT_GAP : RPCAT_STANDBY;
               end
            end
            RPCAT_GAP: begin
               if (gap_over) begin
                  mode_q <= RPCAT_TRANSMIT;
               end
            end
            RPCAT_TRANSMIT: begin
               if (tx_end) begin
                  mode_q <= auto_armed ? RPCAT_RECEIVE : RPCAT_STANDBY;
               end
            end
            default: mode_q <= RPCAT_STANDBY;
         endcase
      end
   end

   // gap counted in whole microseconds; a delay at or under 33 gives no wait
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         us_cnt_q <= 16'h0000;
         pre_cnt_q <= 8'h00;
      end else if ((mode_q == RPCAT_RECEIVE) && rx_end) begin
         us_cnt_q <= (auto_gap_q > MODE_SWITCH_US) ? auto_gap_q - MODE_SWITCH_US : 16'h0000;
         pre_cnt_q <= 8'(CYCLES_PER_US - 1);
      end else if ((mode_q == RPCAT_GAP) && !gap_over) begin
         if (pre_cnt_q == 8'h00) begin
            pre_cnt_q <= 8'(CYCLES_PER_US - 1);
            us_cnt_q <= us_cnt_q - 16'h0001;
         end else if (us_cnt_q == 16'h0000) begin
            pre_cnt_q <= 8'h00;
         end else begin
            pre_cnt_q <= pre_cnt_q - 8'h01;
         end
      end
   end

   // -----------------------------------------------------------------
   // event pulses
   // -----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         tx_start_q <= 1'b0;
         rx_discard_q <= 1'b0;
      end else begin
         tx_start_q <= ((mode_q == RPCAT_GAP) && gap_over)
                       || ((mode_q == RPCAT_STANDBY) && !rx_start && tx_request);
         rx_discard_q <= (mode_q == RPCAT_RECEIVE) && rx_end && oversize;
      end
   end
endmodule

//--- common/rpcat_pkg.sv
// shared constants and types of the radio packet configuration block
package rpcat_pkg;
   // -----------------------------------------------------------------
   // command opcodes
   // -----------------------------------------------------------------
   localparam logic [7:0] OP_AUTO_RESPOND = 8'h98;
   localparam logic [7:0] OP_ENTER_STANDBY = 8'h81;
   localparam logic [7:0] OP_SELECT_KIND = 8'h82;
   localparam logic [7:0] OP_SET_CARRIER = 8'h83;
   localparam logic [7:0] OP_SET_BASES = 8'h84;
   localparam logic [7:0] OP_SET_MODULATION = 8'h85;
   localparam logic [7:0] OP_SET_FORMAT = 8'h86;
   localparam logic [7:0] OP_REGISTER_WRITE = 8'h87;
   localparam logic [3:0] ARGS_AUTO = 4'h2;
   localparam logic [3:0] ARGS_ONE = 4'h1;
   localparam logic [3:0] ARGS_CARRIER = 4'h3;
   localparam logic [3:0] ARGS_BASES = 4'h2;
   localparam logic [3:0] ARGS_MOD = 4'h3;
   localparam logic [3:0] ARGS_FORMAT = 4'h7;
   localparam logic [3:0] ARGS_REG_ADDR = 4'h2;
   localparam logic [3:0] ARGS_MAX = 4'hF;
   localparam int ARG_DEPTH = 8;
   // -----------------------------------------------------------------
   // register addresses
   // -----------------------------------------------------------------
   localparam logic [15:0] ADDR_CRC_POLY_HIGH = 16'h09C6;
   localparam logic [15:0] ADDR_CRC_POLY_LOW = 16'h09C7;
   localparam logic [15:0] ADDR_CRC_SEED_HIGH = 16'h09C8;
   localparam logic [15:0] ADDR_CRC_SEED_LOW = 16'h09C9;
   // -----------------------------------------------------------------
   // parameter codes
   // -----------------------------------------------------------------
   localparam logic [7:0] FAST_LONG_RANGE_KIND = 8'h03;
   localparam logic [7:0] BR_1300 = 8'h45;
   localparam logic [7:0] BR_1040 = 8'h69;
   localparam logic [7:0] BR_650 = 8'h86;
   localparam logic [7:0] BR_520 = 8'hAA;
   localparam logic [7:0] BR_325 = 8'hC7;
   localparam logic [7:0] BR_260 = 8'hEB;
   localparam logic [7:0] CR_HALF = 8'h00;
   localparam logic [7:0] CR_THREE_QUARTER = 8'h02;
   localparam logic [7:0] CR_UNCODED = 8'h04;
   localparam logic [7:0] BT_OFF = 8'h00;
   localparam logic [7:0] BT_ONE = 8'h10;
   localparam logic [7:0] BT_HALF = 8'h20;
   localparam logic [7:0] CODE_STEP_MAX = 8'h70;
   localparam logic [7:0] SYNC_NONE = 8'h00;
   localparam logic [7:0] SYNC_WORD32 = 8'h04;
   localparam logic [7:0] FIXED_SIZE_FRAMES = 8'h00;
   localparam logic [7:0] VARIABLE_SIZE_FRAMES = 8'h20;
   localparam logic [7:0] CRC_THREE = 8'h30;
   localparam logic [7:0] WHITENING_OFF = 8'h08;
   localparam logic [5:0] PREAMBLE_STEP_BITS = 6'h04;
   // -----------------------------------------------------------------
   // timing and frequency
   // -----------------------------------------------------------------
   localparam int CLK_HZ = 200_000_000;
   localparam int CYCLES_PER_US = CLK_HZ / 1_000_000;
   localparam logic [15:0] MODE_SWITCH_US = 16'h0021;
   localparam longint IF_HZ = 1_300_000;
   localparam longint SYNTH_REF_HZ = 52_000_000;
   localparam int SYNTH_FRAC_BITS = 18;
   localparam longint IF_STEPS_L = ((IF_HZ << SYNTH_FRAC_BITS) + SYNTH_REF_HZ / 2) / SYNTH_REF_HZ;
   localparam logic [23:0] IF_STEPS = IF_STEPS_L[23:0];
   // -----------------------------------------------------------------
   // types
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {RPCAT_CAL, RPCAT_STANDBY, RPCAT_RECEIVE, RPCAT_GAP,
                             RPCAT_TRANSMIT} rpcat_mode_type;
   typedef enum logic [2:0] {RATE_1300, RATE_1040, RATE_650, RATE_520, RATE_325,
                             RATE_260} rpcat_rate_type;
   typedef struct packed {
      logic [7:0] packet_kind;
      logic [23:0] tx_carrier_word;
      logic [23:0] rx_carrier_word;
      logic [7:0] transmit_base_offset;
      logic [7:0] receive_base_offset;
      rpcat_rate_type rate;
      logic [1:0] coding_rate;
      logic [1:0] shaping;
      logic [5:0] gain_training_length;
      logic sync_word_on;
      logic [2:0] sync_accept_mask;
      logic variable_size;
      logic [7:0] payload_length;
      logic [1:0] crc_bytes;
      logic [15:0] crc_seed;
      logic [15:0] crc_generator;
   } rpcat_cfg_type;
endpackage

//--- dv/rpcat_core_asserts.sv
// assertion checker for the packet configuration block
`timescale 1ns/1ps
module rpcat_core_asserts #(
   parameter int CAL_CYCLES = 1024
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic cmd_valid,
   input wire logic cmd_start,
   input wire logic [7:0] cmd_data,
   input wire logic rx_start,
   input wire logic tx_request,
   input wire logic rx_end,
   input wire logic [7:0] rx_len,
   input wire logic tx_end,
   input wire logic busy,
   input wire rpcat_pkg::rpcat_mode_type mode,
   input wire logic auto_armed,
   input wire logic tx_start,
   input wire logic rx_discard,
   input wire logic param_error,
   input wire rpcat_pkg::rpcat_cfg_type cfg
);
   import rpcat_pkg::*;
   logic oversize;
   assign oversize = cfg.variable_size && (rx_len > cfg.payload_length);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // -----------------------------------------------------------------
   // properties
   // -----------------------------------------------------------------
   busy_mode_a: assert property (busy == (mode != RPCAT_STANDBY))
      else $error("busy disagrees with mode");
   cal_exit_a: assert property ($past(mode) == RPCAT_CAL && mode != RPCAT_CAL
      |-> mode == RPCAT_STANDBY) else $error("calibration left to wrong mode");
   armed_rx_a: assert property (mode == RPCAT_RECEIVE && rx_end && auto_armed && !oversize
      |=> mode == RPCAT_GAP) else $error("armed reception did not start gap");
   plain_rx_a: assert property (mode == RPCAT_RECEIVE && rx_end && !auto_armed && !oversize
      |=> mode == RPCAT_STANDBY) else $error("unarmed reception did not end in standby");
   drop_long_a: assert property (mode == RPCAT_RECEIVE && rx_end && oversize
      |=> rx_discard && mode == RPCAT_RECEIVE) else $error("oversize packet not dropped");
   gap_exit_a: assert property ($past(mode) == RPCAT_GAP && mode != RPCAT_GAP
      |-> mode == RPCAT_TRANSMIT) else $error("gap ended without transmit");
   tx_once_a: assert property (tx_start |=> !tx_start)
      else $error("transmit start longer than one cycle");
   tx_done_a: assert property (mode == RPCAT_TRANSMIT && tx_end
      |=> mode == (auto_armed ? RPCAT_RECEIVE : RPCAT_STANDBY)) else $error("bad mode after tx");
   arm_code_a: assert property ((cmd_valid && cmd_start && cmd_data == OP_AUTO_RESPOND && !busy)
      ##1 (cmd_valid && !cmd_start) [*2]
      |=> auto_armed == ($past(cmd_data, 2) != 8'h00 || $past(cmd_data) != 8'h00))
      else $error("armed flag does not follow delay");
   busy_deaf_a: assert property (mode != RPCAT_STANDBY && cmd_valid |=> $stable(cfg))
      else $error("command taken while busy");
endmodule
bind rpcat_core rpcat_core_asserts #(.CAL_CYCLES(CAL_CYCLES)) u_asserts (
   .ref_clk(ref_clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_start(cmd_start),
   .cmd_data(cmd_data), .rx_start(rx_start), .tx_request(tx_request), .rx_end(rx_end),
   .rx_len(rx_len), .tx_end(tx_end), .busy(busy), .mode(mode), .auto_armed(auto_armed),
   .tx_start(tx_start), .rx_discard(rx_discard), .param_error(param_error), .cfg(cfg));

//--- dv/rpcat_host.sv
// host controller model that sends configuration commands
`timescale 1ns/1ps
module rpcat_host (
   input wire logic ref_clk,
   output logic cmd_valid,
   output logic cmd_start,
   output logic [7:0] cmd_data
);
   import rpcat_pkg::*;
   initial begin
      cmd_valid = 1'b0;
      cmd_start = 1'b0;
      cmd_data = 8'h00;
   end
   // -----------------------------------------------------------------
   // one command: opcode then n bytes, high byte first
   // -----------------------------------------------------------------
   task automatic send_cmd(input logic [7:0] op, input int n, input logic [55:0] args);
      @(negedge ref_clk);
      cmd_valid = 1'b1;
      cmd_start = 1'b1;
      cmd_data = op;
      for (int i = n - 1; i >= 0; i--) begin
         @(negedge ref_clk);
         cmd_start = 1'b0;
         cmd_data = args[8*i +: 8];
      end
      @(negedge ref_clk);
      cmd_valid = 1'b0;
   endtask
   // -----------------------------------------------------------------
   // bring-up in documented order; preamble 16 bits suits every rate
   // -----------------------------------------------------------------
   task automatic configure(input logic [7:0] br, input logic [7:0] cr, input logic [7:0] bt);
      send_cmd(OP_ENTER_STANDBY, 1, 56'h0);
      send_cmd(OP_SELECT_KIND, 1, {48'h0, FAST_LONG_RANGE_KIND});
      send_cmd(OP_SET_CARRIER, 3, 56'h123456);
      send_cmd(OP_SET_BASES, 2, 56'h1080);
      send_cmd(OP_SET_MODULATION, 3, {32'h0, br, cr, bt});
      send_cmd(OP_SET_FORMAT, 7, {8'h30, SYNC_WORD32, 8'h50, VARIABLE_SIZE_FRAMES, 8'h06,
         CRC_THREE, WHITENING_OFF});
   endtask
endmodule

//--- dv/tb_radio_packet_config_autotx.sv
// self-checking bench for the packet configuration block
`timescale 1ns/1ps
module tb_radio_packet_config_autotx;
   import rpcat_pkg::*;
   localparam int CAL = 4;
   logic ref_clk, resetn, cmd_valid, cmd_start, rx_start, tx_request, rx_end, tx_end;
   logic [7:0] cmd_data, rx_len;
   logic busy, auto_armed, tx_start, rx_discard, param_error;
   rpcat_mode_type mode;
   rpcat_cfg_type cfg;
   int err_count = 0;
   int tests_run = 0;
   int tx_seen = 0;
   int drop_seen = 0;
   rpcat_core #(.CAL_CYCLES(CAL)) dut (.ref_clk(ref_clk), .resetn(resetn),
      .cmd_valid(cmd_valid), .cmd_start(cmd_start), .cmd_data(cmd_data), .rx_start(rx_start),
      .tx_request(tx_request), .rx_end(rx_end), .rx_len(rx_len), .tx_end(tx_end), .busy(busy),
      .mode(mode), .auto_armed(auto_armed), .tx_start(tx_start), .rx_discard(rx_discard),
      .param_error(param_error), .cfg(cfg));
   rpcat_host host (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_start(cmd_start),
      .cmd_data(cmd_data));
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   // single-cycle outputs are counted at the edge, judged later
   always @(posedge ref_clk) begin
      if (tx_start === 1'b1) tx_seen++;
      if (rx_discard === 1'b1) drop_seen++;
   end
   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   // sel order: rx_start, tx_request, rx_end, tx_end
   task automatic pulse(input logic [3:0] sel);
      @(negedge ref_clk);
      {rx_start, tx_request, rx_end, tx_end} = sel;
      @(negedge ref_clk);
      {rx_start, tx_request, rx_end, tx_end} = 4'h0;
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   task automatic t_reset;
      int n;
      n = 0;
      chk(mode, RPCAT_CAL);
      chk(busy, 1'b1);
      resetn = 1'b1;
      while (busy !== 1'b0 && n < 50) begin
         step(1);
         n++;
      end
      chk(n >= CAL && n <= CAL + 2, 1);
      chk(mode, RPCAT_STANDBY);
      $display("reset test done");
   endtask
   task automatic t_config;
      logic [7:0] brs [6] = '{BR_1300, BR_1040, BR_650, BR_520, BR_325, BR_260};
      rpcat_rate_type rts [6] = '{RATE_1300, RATE_1040, RATE_650, RATE_520, RATE_325, RATE_260};
      logic [7:0] crs [3] = '{CR_HALF, CR_THREE_QUARTER, CR_UNCODED};
      logic [7:0] bts [3] = '{BT_OFF, BT_ONE, BT_HALF};
      for (int i = 0; i < 6; i++) begin
         host.configure(brs[i], crs[i % 3], bts[i % 3]);
         step(1);
         chk(cfg.rate, rts[i]);
         chk(cfg.coding_rate, crs[i % 3][2:1]);
         chk(cfg.shaping, bts[i % 3][5:4]);
         chk(param_error, 1'b0);
      end
      chk(cfg.packet_kind, FAST_LONG_RANGE_KIND);
      chk(cfg.tx_carrier_word, 24'h123456);
      chk(cfg.rx_carrier_word, 24'h123456 - IF_STEPS);
      chk(cfg.transmit_base_offset, 8'h10);
      chk(cfg.receive_base_offset, 8'h80);
      chk(cfg.gain_training_length, 6'h10);
      chk(cfg.sync_word_on, 1'b1);
      chk(cfg.sync_accept_mask, 3'h5);
      chk(cfg.variable_size, 1'b1);
      chk(cfg.payload_length, 8'h06);
      chk(cfg.crc_bytes, 2'h3);
      $display("config test done");
   endtask
   task automatic t_reserved;
      host.send_cmd(OP_SET_MODULATION, 3, {32'h0, BR_650, 8'h06, BT_OFF});
      chk(param_error, 1'b1);
      chk(cfg.rate, RATE_260);
      host.send_cmd(OP_SET_MODULATION, 3, {32'h0, BR_260, CR_HALF, BT_OFF});
      chk(param_error, 1'b0);
      host.send_cmd(OP_SET_FORMAT, 7, {8'h00, SYNC_WORD32, 8'h50, VARIABLE_SIZE_FRAMES, 8'h06,
         CRC_THREE, WHITENING_OFF});
      chk(param_error, 1'b1);
      chk(cfg.gain_training_length, 6'h10);
      host.send_cmd(OP_REGISTER_WRITE, 6, {8'h0, ADDR_CRC_POLY_HIGH, 32'hA1B2C3D4});
      chk(cfg.crc_generator, 16'hA1B2);
      chk(cfg.crc_seed, 16'hC3D4);
      host.send_cmd(OP_SET_FORMAT, 7, {8'h70, SYNC_NONE, 8'h00, FIXED_SIZE_FRAMES, 8'h7F, 8'h00,
         WHITENING_OFF});
      chk(cfg.gain_training_length, 6'h20);
      chk(cfg.sync_accept_mask, 3'h0);
      chk(cfg.payload_length, 8'h7F);
      chk({cfg.sync_word_on, cfg.variable_size, cfg.crc_bytes, param_error}, 5'h00);
      host.configure(BR_260, CR_HALF, BT_OFF);
      chk(cfg.variable_size, 1'b1);
      $display("reserved and register test done");
   endtask
   task automatic t_normal_tx;
      int n;
      host.send_cmd(OP_AUTO_RESPOND, 2, 56'h0023);
      chk(auto_armed, 1'b1);
      host.send_cmd(OP_AUTO_RESPOND, 2, 56'h0);
      chk(auto_armed, 1'b0);
      n = tx_seen;
      pulse(4'b0100);
      step(1);
      chk(tx_seen - n, 1);
      chk(mode, RPCAT_TRANSMIT);
      host.send_cmd(OP_AUTO_RESPOND, 2, 56'h0023);
      chk(auto_armed, 1'b0);
      pulse(4'b0001);
      chk(mode, RPCAT_STANDBY);
      $display("normal transmit test done");
   endtask
   task automatic t_turnaround;
      int n;
      int c;
      int g;
      g = (16'h0023 - MODE_SWITCH_US) * CYCLES_PER_US;
      host.send_cmd(OP_AUTO_RESPOND, 2, 56'h0023);
      pulse(4'b1000);
      chk(mode, RPCAT_RECEIVE);
      rx_len = 8'h07;
      pulse(4'b0010);
      step(1);
      chk(drop_seen, 1);
      chk(mode, RPCAT_RECEIVE);
      rx_len = 8'h06;
      n = tx_seen;
      pulse(4'b0010);
      chk(mode, RPCAT_GAP);
      c = 1;
      while (mode !== RPCAT_TRANSMIT && c < 1000) begin
         step(1);
         c++;
      end
      chk(c >= g - 2 && c <= g + 3, 1);
      step(1);
      chk(tx_seen - n, 1);
      pulse(4'b0001);
      chk(mode, RPCAT_RECEIVE);
      $display("turnaround test done");
   endtask
   // -----------------------------------------------------------------
   // main sequence and watchdog
   // -----------------------------------------------------------------
   initial begin
      resetn = 1'b0;
      {rx_start, tx_request, rx_end, tx_end} = 4'h0;
      rx_len = 8'h00;
      step(6);
      t_reset();
      t_config();
      t_reserved();
      t_normal_tx();
      t_turnaround();
      tally_and_finish();
   end
   initial begin
      #100000;
      err_count++;
      tally_and_finish();
   end
endmodule
